// ===== rtl/hspf_dev.sv
// Device end of the host serial port: character engine, receive FIFO,
// packetisation, throttling and API escaping.
// Assumes the radio side handshakes with valid and ready on the core clock.
`timescale 1ns/100ps

module hspf_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       ce_i,
  input  wire logic                       in_valid_i,
  input  wire logic [W-1:0]               in_data_i,
  output logic                            in_ready_o,
  output logic                            out_valid_o,
  output logic [W-1:0]                    out_data_o,
  input  wire logic                       out_ready_i,
  output logic [$clog2(DEPTH):0]          count_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } hspf_fifo_st_t;
  hspf_fifo_st_t s_reg;
  hspf_fifo_st_t s_next;
  logic [W-1:0]  mem [DEPTH];
  logic          push;
  logic          pop;

  assign in_ready_o  = s_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid_o = s_reg.cnt != '0;
  assign out_data_o  = mem[s_reg.rp];
  assign count_o     = s_reg.cnt;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.wp = (s_reg.wp == AW'(DEPTH-1)) ? '0 : s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = (s_reg.rp == AW'(DEPTH-1)) ? '0 : s_reg.rp + 1'b1;
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[s_reg.wp] <= in_data_i;
    end
  end
endmodule : hspf_fifo

module hspf_uart (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  input  wire logic [31:0] bit_cyc_i,
  input  wire logic [1:0]  parity_i,
  input  wire logic        two_stop_i,
  input  wire logic        tx_valid_i,
  input  wire logic [7:0]  tx_data_i,
  output logic             tx_ready_o,
  output logic             txd_o,
  input  wire logic        rxd_i,
  output logic             rx_valid_o,
  output logic [7:0]       rx_data_o,
  output logic             rx_err_o
);
  typedef struct packed {
    logic [31:0] tcnt;
    logic [3:0]  tleft;
    logic [10:0] tsh;
    logic        txd;
    logic [31:0] rcnt;
    logic [3:0]  rleft;
    logic [11:0] rsh;
    logic        rxv;
    logic [7:0]  rxd;
    logic        rxe;
  } hspf_uart_st_t;
  hspf_uart_st_t s_reg;
  hspf_uart_st_t s_next;
  logic          par_en;
  logic          odd;
  logic [3:0]    tn;
  logic [3:0]    rn;
  logic [11:0]   sh;
  logic [7:0]    rdata;

  assign par_en     = parity_i == hspf_pkg::PAR_EVEN ||
                      parity_i == hspf_pkg::PAR_ODD;
  assign odd        = parity_i == hspf_pkg::PAR_ODD;
  assign tn         = hspf_pkg::CHAR_BITS_BASE + 4'(par_en)
                      + 4'(two_stop_i);
  assign rn         = hspf_pkg::CHAR_BITS_BASE + 4'(par_en);
  assign sh         = {rxd_i, s_reg.rsh[11:1]};
  assign rdata      = par_en ? sh[9:2] : sh[10:3];
  assign tx_ready_o = s_reg.tleft == '0;
  assign txd_o      = s_reg.txd;
  assign rx_valid_o = s_reg.rxv;
  assign rx_data_o  = s_reg.rxd;
  assign rx_err_o   = s_reg.rxe;

  always_comb begin
    s_next = s_reg;
    s_next.rxv = 1'b0;
    if (s_reg.tleft == '0) begin
      if (tx_valid_i) begin
        s_next.txd   = 1'b0;
        s_next.tsh   = par_en ? {2'h3, ^tx_data_i ^ odd, tx_data_i}
                              : {3'h7, tx_data_i};
        s_next.tleft = tn;
        s_next.tcnt  = bit_cyc_i - 32'h1;
      end
    end else if (s_reg.tcnt == '0) begin
      s_next.tleft = s_reg.tleft - 4'h1;
      s_next.tcnt  = bit_cyc_i - 32'h1;
      s_next.txd   = (s_reg.tleft == 4'h1) ? 1'b1 : s_reg.tsh[0];
      s_next.tsh   = {1'b1, s_reg.tsh[10:1]};
    end else begin
      s_next.tcnt = s_reg.tcnt - 32'h1;
    end
    if (s_reg.rleft == '0) begin
      if (!rxd_i) begin
        s_next.rleft = rn;
        s_next.rcnt  = {1'b0, bit_cyc_i[31:1]};
      end
    end else if (s_reg.rcnt == '0) begin
      s_next.rcnt  = bit_cyc_i - 32'h1;
      s_next.rleft = s_reg.rleft - 4'h1;
      s_next.rsh   = sh;
      if (s_reg.rleft == rn && rxd_i) begin
        s_next.rleft = '0;
      end else if (s_reg.rleft == 4'h1) begin
        s_next.rxv = 1'b1;
        s_next.rxd = rdata;
        s_next.rxe = !sh[11] || (par_en && (sh[10] != (^rdata ^ odd)));
      end
    end else begin
      s_next.rcnt = s_reg.rcnt - 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg     <= '0;
      s_reg.txd <= 1'b1;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end
endmodule : hspf_uart

module hspf_dev #(
  parameter int DEPTH = 16
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        CE_I,
  hspf_if.dev              LINK,
  input  wire logic        CFG_WE_I,
  input  wire logic [23:0] BIT_RATE_SELECT_I,
  input  wire logic [1:0]  PARITY_SELECT_I,
  input  wire logic        STOP_BIT_COUNT_I,
  input  wire logic [7:0]  PACKET_SILENCE_TIMEOUT_I,
  input  wire logic [8:0]  RX_BUFFER_THROTTLE_LEVEL_I,
  input  wire logic [1:0]  HOST_FRAMING_MODE_I,
  input  wire logic        RX_FRAME_FORMAT_OPTION_I,
  input  wire logic        XOFF_ENABLE_I,
  output logic             RF_TX_VALID_O,
  output logic [7:0]       RF_TX_DATA_O,
  output logic             RF_TX_SOF_O,
  output logic             RF_TX_LAST_O,
  input  wire logic        RF_TX_READY_I,
  input  wire logic        RF_RX_VALID_I,
  input  wire logic [7:0]  RF_RX_DATA_I,
  input  wire logic        RF_RX_SOF_I,
  output logic             RF_RX_READY_O,
  output logic [7:0]       RX_FRAME_TYPE_O,
  output logic             THROTTLED_O
);
  localparam int CW = $clog2(DEPTH) + 1;
  typedef struct packed {
    logic [23:0]   rate;
    logic [1:0]    par;
    logic          stop;
    logic [7:0]    sil;
    logic [8:0]    thr;
    logic [1:0]    mode;
    logic          ao;
    logic          xoff_en;
    logic [31:0]   cyc;
    logic [7:0]    chars;
    logic [CW-1:0] pkt;
    logic          unesc;
    logic          esc_pend;
    logic [7:0]    esc_byte;
    logic          throttled;
    logic          xon_pend;
    logic          xoff_pend;
  } hspf_dev_st_t;
  hspf_dev_st_t  s_reg;
  hspf_dev_st_t  s_next;
  logic [31:0]   bit_cyc;
  logic [31:0]   char_cyc;
  logic          urx_v;
  logic [7:0]    urx_d;
  logic          utx_v;
  logic [7:0]    utx_d;
  logic          utx_rdy;
  logic          f_in_v;
  logic [8:0]    f_in_d;
  logic          f_in_rdy;
  logic          f_out_v;
  logic [8:0]    f_out_d;
  logic          f_out_rdy;
  logic [CW-1:0] f_cnt;
  logic [9:0]    cnt10;
  logic          is_esc;
  logic          raw;
  logic          drain;
  logic          rf_take;

  assign bit_cyc  = hspf_pkg::bit_cycles(s_reg.rate);
  assign char_cyc = bit_cyc * {28'h0, hspf_pkg::CHAR_BITS_BASE
                    + 4'(s_reg.par != hspf_pkg::PAR_NONE) + 4'(s_reg.stop)};
  assign raw      = s_reg.mode == hspf_pkg::MODE_RAW;
  assign is_esc   = s_reg.mode == hspf_pkg::MODE_API_ESC
                    && urx_d == hspf_pkg::API_ESC && !s_reg.unesc;
  assign f_in_v   = urx_v && !is_esc;
  assign f_in_d   = {!raw && urx_d == hspf_pkg::API_DELIM && !s_reg.unesc,
                     s_reg.unesc ? urx_d ^ hspf_pkg::ESC_MASK
                                 : urx_d};
  assign cnt10    = 10'(f_cnt);
  assign drain    = !raw || s_reg.pkt != '0;
  assign f_out_rdy     = RF_TX_READY_I && drain;
  assign RF_TX_VALID_O = f_out_v && drain;
  assign RF_TX_DATA_O  = f_out_d[7:0];
  assign RF_TX_SOF_O   = f_out_d[8];
  assign RF_TX_LAST_O  = raw && s_reg.pkt == CW'(1);
  assign RF_RX_READY_O = utx_rdy && !s_reg.xoff_pend && !s_reg.xon_pend
                         && !s_reg.esc_pend;
  assign rf_take       = RF_RX_READY_O && RF_RX_VALID_I;
  assign RX_FRAME_TYPE_O = s_reg.ao ? hspf_pkg::FRAME_EXPL
                                    : hspf_pkg::FRAME_STD;
  assign THROTTLED_O   = s_reg.throttled;
  assign LINK.cts_b    = s_reg.throttled;

  always_comb begin
    utx_v = 1'b0;
    utx_d = RF_RX_DATA_I;
    if (s_reg.xoff_pend) begin
      utx_v = 1'b1;
      utx_d = hspf_pkg::CHAR_XOFF;
    end else if (s_reg.xon_pend) begin
      utx_v = 1'b1;
      utx_d = hspf_pkg::CHAR_XON;
    end else if (s_reg.esc_pend) begin
      utx_v = 1'b1;
      utx_d = s_reg.esc_byte;
    end else if (RF_RX_VALID_I) begin
      utx_v = 1'b1;
      if (s_reg.mode == hspf_pkg::MODE_API_ESC && !RF_RX_SOF_I
          && hspf_pkg::needs_escape(RF_RX_DATA_I)) begin
        utx_d = hspf_pkg::API_ESC;
      end
    end
  end

  always_comb begin
    s_next = s_reg;
    if (CFG_WE_I) begin
      s_next.rate    = BIT_RATE_SELECT_I;
      s_next.par     = PARITY_SELECT_I;
      s_next.stop    = STOP_BIT_COUNT_I;
      s_next.sil     = PACKET_SILENCE_TIMEOUT_I;
      s_next.thr     = RX_BUFFER_THROTTLE_LEVEL_I;
      s_next.mode    = HOST_FRAMING_MODE_I;
      s_next.ao      = RX_FRAME_FORMAT_OPTION_I;
      s_next.xoff_en = XOFF_ENABLE_I;
    end
    if (urx_v) begin
      s_next.unesc = is_esc;
      s_next.cyc   = '0;
      s_next.chars = '0;
    end else if (s_reg.chars != hspf_pkg::SILENCE_MAX) begin
      if (s_reg.cyc + 32'h1 >= char_cyc) begin
        s_next.cyc   = '0;
        s_next.chars = s_reg.chars + 8'h1;
      end else begin
        s_next.cyc = s_reg.cyc + 32'h1;
      end
    end
    if (raw && s_reg.pkt == '0 && f_cnt != '0 && s_reg.chars >= s_reg.sil) begin
      s_next.pkt = (s_reg.sil == '0) ? CW'(1) : f_cnt;
    end else if (raw && f_out_v && f_out_rdy) begin
      s_next.pkt = s_reg.pkt - CW'(1);
    end
    if (utx_rdy && s_reg.xoff_pend) begin
      s_next.xoff_pend = 1'b0;
    end else if (utx_rdy && s_reg.xon_pend) begin
      s_next.xon_pend = 1'b0;
    end else if (utx_rdy && s_reg.esc_pend) begin
      s_next.esc_pend = 1'b0;
    end else if (rf_take && utx_d == hspf_pkg::API_ESC
                 && s_reg.mode == hspf_pkg::MODE_API_ESC && !RF_RX_SOF_I) begin
      s_next.esc_pend = 1'b1;
      s_next.esc_byte = RF_RX_DATA_I ^ hspf_pkg::ESC_MASK;
    end
    if (!s_reg.throttled && (cnt10 >= {1'b0, s_reg.thr} || !f_in_rdy
        || f_cnt >= CW'(DEPTH-2))) begin
      s_next.throttled = 1'b1;
      s_next.xoff_pend = s_reg.xoff_en;
      s_next.xon_pend  = 1'b0;
    end else if (s_reg.throttled && cnt10 + hspf_pkg::THROTTLE_HYST
                 < {1'b0, s_reg.thr} && f_cnt < CW'(DEPTH/2)) begin
      s_next.throttled = 1'b0;
      s_next.xon_pend  = s_reg.xoff_en;
      s_next.xoff_pend = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s_reg      <= '0;
      s_reg.rate <= hspf_pkg::RATE_SEL_RST;
      s_reg.par  <= hspf_pkg::PAR_NONE;
      s_reg.stop <= hspf_pkg::STOP_RST;
      s_reg.sil  <= hspf_pkg::SILENCE_RST;
      s_reg.thr  <= hspf_pkg::THROTTLE_RST;
      s_reg.mode <= hspf_pkg::MODE_RAW;
      s_reg.ao   <= hspf_pkg::AO_RST;
    end else if (CE_I) begin
      s_reg <= s_next;
    end
  end

  hspf_uart u_uart (
    .clk_i      (CORE_CLK_I),
    .rst_b_i    (RST_B_I),
    .ce_i       (CE_I),
    .bit_cyc_i  (bit_cyc),
    .parity_i   (s_reg.par),
    .two_stop_i (s_reg.stop),
    .tx_valid_i (utx_v),
    .tx_data_i  (utx_d),
    .tx_ready_o (utx_rdy),
    .txd_o      (LINK.dout),
    .rxd_i      (LINK.din),
    .rx_valid_o (urx_v),
    .rx_data_o  (urx_d),
    .rx_err_o   ()
  );

  hspf_fifo #(.W(9), .DEPTH(DEPTH)) u_rxbuf (
    .clk_i       (CORE_CLK_I),
    .rst_b_i     (RST_B_I),
    .ce_i        (CE_I),
    .in_valid_i  (f_in_v),
    .in_data_i   (f_in_d),
    .in_ready_o  (f_in_rdy),
    .out_valid_o (f_out_v),
    .out_data_o  (f_out_d),
    .out_ready_i (f_out_rdy),
    .count_o     (f_cnt)
  );
endmodule : hspf_dev

// ===== rtl/hspf_pkg.sv
// Shared constants, defaults and helpers for the host serial port blocks.
// Assumes a single 250 MHz core clock on both ends of the serial link.
package hspf_pkg;

  localparam int unsigned CLK_PERIOD_PS = 32'h0000_0FA0;
  localparam int unsigned CLK_HZ        = 32'h3B9A_CA00 / CLK_PERIOD_PS
                                          * 32'h0000_03E8;

  localparam logic [23:0] RATE_SEL_RST    = 24'h00_0003;
  localparam logic [23:0] RATE_SEL_FIRST  = 24'h00_0001;
  localparam logic [23:0] RATE_SEL_LAST   = 24'h00_0008;
  localparam logic [23:0] RATE_SEL_DIRECT = 24'h00_0039;
  localparam logic [31:0] PRESET_BPS [1:8] = '{
    32'h0000_0960, 32'h0000_12C0, 32'h0000_2580, 32'h0000_4B00,
    32'h0000_9600, 32'h0000_E100, 32'h0001_C200, 32'h0003_8400};

  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic       STOP_RST = 1'h0;
  localparam logic [3:0] CHAR_BITS_BASE = 4'hA;

  localparam logic [7:0] SILENCE_RST   = 8'h03;
  localparam logic [7:0] SILENCE_MAX   = 8'hFF;
  localparam logic [8:0] THROTTLE_RST  = 9'h13F;
  localparam logic [9:0] THROTTLE_HYST = 10'h010;

  localparam logic [1:0] MODE_RAW     = 2'h0;
  localparam logic [1:0] MODE_API     = 2'h1;
  localparam logic [1:0] MODE_API_ESC = 2'h2;
  localparam logic       AO_RST       = 1'h0;

  localparam logic [7:0] FRAME_STD  = 8'h90;
  localparam logic [7:0] FRAME_EXPL = 8'h91;
  localparam logic [7:0] API_DELIM  = 8'h7E;
  localparam logic [7:0] API_ESC    = 8'h7D;
  localparam logic [7:0] CHAR_XON   = 8'h11;
  localparam logic [7:0] CHAR_XOFF  = 8'h13;
  localparam logic [7:0] ESC_MASK   = 8'h20;

  localparam logic [11:0] REG_CFG  = 12'h000;
  localparam logic [11:0] REG_TX   = 12'h004;
  localparam logic [11:0] REG_RX   = 12'h008;
  localparam logic [11:0] REG_STAT = 12'h00C;
  localparam int CFG_PAR_LSB  = 24;
  localparam int CFG_STOP     = 26;
  localparam int CFG_MODE_LSB = 27;
  localparam int CFG_CTS      = 29;
  localparam int DATA_SOF     = 8;
  localparam int RX_ERR       = 9;
  localparam int RX_VALID     = 10;
  localparam int STAT_IDLE    = 5;
  localparam int STAT_CTS     = 6;
  localparam int STAT_OVR     = 7;

  // Converts a rate-select value to core clock cycles per bit.
  function automatic logic [31:0] bit_cycles(input logic [23:0] sel);
    logic [31:0] bps;
    bps = PRESET_BPS[RATE_SEL_RST[3:0]];
    if (sel >= RATE_SEL_DIRECT) begin
      bps = {8'h00, sel};
    end else if (sel >= RATE_SEL_FIRST && sel <= RATE_SEL_LAST) begin
      bps = PRESET_BPS[sel[3:0]];
    end
    return CLK_HZ / bps;
  endfunction : bit_cycles

  // True for the bytes that escaped API framing must hide.
  function automatic logic needs_escape(input logic [7:0] b);
    return b == API_DELIM || b == API_ESC || b == CHAR_XON || b == CHAR_XOFF;
  endfunction : needs_escape

endpackage : hspf_pkg

// ===== rtl/hspf_if.sv
// Serial link between the device end and the host end.
// Assumes both ends share the core clock; din and dout idle high, cts_b idles low.
`timescale 1ns/100ps
interface hspf_if;
  logic din;
  logic dout;
  logic cts_b;
  modport dev (input din, output dout, output cts_b);
  modport host (output din, input dout, input cts_b);
endinterface : hspf_if

// ===== rtl/hspf_host.sv
// Host end of the serial port: an APB register slave driving the link.
// Assumes the character engine and FIFO from the device file are compiled.
`timescale 1ns/100ps
module hspf_host #(
  parameter int TX_DEPTH = 16
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        CE_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  hspf_if.host             LINK
);
  localparam int CW = $clog2(TX_DEPTH) + 1;
  typedef struct packed {
    logic [29:0] cfg;
    logic        rxv;
    logic [8:0]  rxd;
    logic        rxe;
    logic        ovr;
    logic        unesc;
    logic        esc_pend;
    logic [7:0]  esc_byte;
    logic [31:0] prdata;
  } hspf_host_st_t;
  hspf_host_st_t s_reg;
  hspf_host_st_t s_next;
  logic [1:0]    mode;
  logic          mapped;
  logic          acc;
  logic          go;
  logic          urx_v;
  logic [7:0]    urx_d;
  logic          urx_e;
  logic          utx_v;
  logic [7:0]    utx_d;
  logic          utx_rdy;
  logic          f_in_rdy;
  logic          f_out_v;
  logic [8:0]    f_out_d;
  logic          f_out_rdy;
  logic [CW-1:0] f_cnt;
  logic          esc_now;

  assign mode   = s_reg.cfg[hspf_pkg::CFG_MODE_LSB +: 2];
  assign mapped = PADDR_I == hspf_pkg::REG_CFG || PADDR_I == hspf_pkg::REG_TX
                  || PADDR_I == hspf_pkg::REG_RX
                  || PADDR_I == hspf_pkg::REG_STAT;
  assign PREADY_O  = !(PWRITE_I && PADDR_I == hspf_pkg::REG_TX && !f_in_rdy);
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
  assign PRDATA_O  = s_reg.prdata;
  assign acc       = PSEL_I && PENABLE_I && PREADY_O;
  assign go        = utx_rdy && (!s_reg.cfg[hspf_pkg::CFG_CTS] || !LINK.cts_b);
  assign esc_now   = mode == hspf_pkg::MODE_API_ESC && !f_out_d[8]
                     && hspf_pkg::needs_escape(f_out_d[7:0]);
  assign f_out_rdy = go && !s_reg.esc_pend;
  assign utx_v     = go && (s_reg.esc_pend || f_out_v);
  assign utx_d     = s_reg.esc_pend ? s_reg.esc_byte
                     : esc_now ? hspf_pkg::API_ESC : f_out_d[7:0];

  always_comb begin
    s_next = s_reg;
    if (PSEL_I && !PENABLE_I) begin
      s_next.prdata = '0;
      unique case (PADDR_I)
        hspf_pkg::REG_CFG:  s_next.prdata = {2'h0, s_reg.cfg};
        hspf_pkg::REG_RX:   s_next.prdata = {21'h0, s_reg.rxv, s_reg.rxe,
                                             s_reg.rxd};
        hspf_pkg::REG_STAT: s_next.prdata = {24'h0, s_reg.ovr, LINK.cts_b,
                                             utx_rdy && !f_out_v,
                                             5'(f_cnt)};
        default:            s_next.prdata = '0;
      endcase
    end
    if (acc && PWRITE_I && PADDR_I == hspf_pkg::REG_CFG) begin
      s_next.cfg = PWDATA_I[29:0];
    end
    if (acc && PWRITE_I && PADDR_I == hspf_pkg::REG_STAT
        && PWDATA_I[hspf_pkg::STAT_OVR]) begin
      s_next.ovr = 1'b0;
    end
    if (acc && !PWRITE_I && PADDR_I == hspf_pkg::REG_RX
        && s_reg.prdata[hspf_pkg::RX_VALID]) begin
      s_next.rxv = 1'b0;
    end
    if (urx_v) begin
      if (mode == hspf_pkg::MODE_API_ESC && urx_d == hspf_pkg::API_ESC
          && !s_reg.unesc) begin
        s_next.unesc = 1'b1;
      end else begin
        s_next.ovr   = s_next.ovr || s_next.rxv;
        s_next.rxv   = 1'b1;
        s_next.rxe   = urx_e;
        s_next.unesc = 1'b0;
        s_next.rxd   = {mode != hspf_pkg::MODE_RAW && !s_reg.unesc
                        && urx_d == hspf_pkg::API_DELIM,
                        s_reg.unesc ? urx_d ^ hspf_pkg::ESC_MASK
                                    : urx_d};
      end
    end
    if (go && s_reg.esc_pend) begin
      s_next.esc_pend = 1'b0;
    end else if (f_out_v && f_out_rdy && esc_now) begin
      s_next.esc_pend = 1'b1;
      s_next.esc_byte = f_out_d[7:0] ^ hspf_pkg::ESC_MASK;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s_reg <= '0;
      s_reg.cfg[23:0] <= hspf_pkg::RATE_SEL_RST;
      s_reg.cfg[hspf_pkg::CFG_STOP] <= hspf_pkg::STOP_RST;
      s_reg.cfg[hspf_pkg::CFG_CTS] <= 1'b1;
    end else if (CE_I) begin
      s_reg <= s_next;
    end
  end

  hspf_uart u_uart (
    .clk_i      (CORE_CLK_I),
    .rst_b_i    (RST_B_I),
    .ce_i       (CE_I),
    .bit_cyc_i  (hspf_pkg::bit_cycles(s_reg.cfg[23:0])),
    .parity_i   (s_reg.cfg[hspf_pkg::CFG_PAR_LSB +: 2]),
    .two_stop_i (s_reg.cfg[hspf_pkg::CFG_STOP]),
    .tx_valid_i (utx_v),
    .tx_data_i  (utx_d),
    .tx_ready_o (utx_rdy),
    .txd_o      (LINK.din),
    .rxd_i      (LINK.dout),
    .rx_valid_o (urx_v),
    .rx_data_o  (urx_d),
    .rx_err_o   (urx_e)
  );

  hspf_fifo #(.W(9), .DEPTH(TX_DEPTH)) u_txbuf (
    .clk_i       (CORE_CLK_I),
    .rst_b_i     (RST_B_I),
    .ce_i        (CE_I),
    .in_valid_i  (acc && PWRITE_I && PADDR_I == hspf_pkg::REG_TX),
    .in_data_i   (PWDATA_I[8:0]),
    .in_ready_o  (f_in_rdy),
    .out_valid_o (f_out_v),
    .out_data_o  (f_out_d),
    .out_ready_i (f_out_rdy),
    .count_o     (f_cnt)
  );
endmodule : hspf_host

// ===== sim/hspf_properties.sv
// Link checker: bit timing, idle lines and clear-to-send.
// Assumes bit times of 35 core clocks and even parity.
`timescale 1ns/100ps
module hspf_properties (
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  input wire logic din,
  input wire logic dout,
  input wire logic cts_b
);
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  sequence s_hold(l);
    $stable(l)[*7];
  endsequence
  sequence s_back(l);
    ##[1:360] l;
  endsequence
  AST_DI_BIT: assert property ($changed(din) |=> s_hold(din))
    else $error("din bit short");
  AST_DO_BIT: assert property ($changed(dout) |=> s_hold(dout))
    else $error("dout bit short");
  AST_DI_STOP: assert property ($fell(din) |-> s_back(din))
    else $error("din stop late");
  AST_DO_STOP: assert property ($fell(dout) |-> s_back(dout))
    else $error("dout stop late");
  AST_IDLE: assert property ($rose(RST_B_I) |-> din && dout)
    else $error("line not idle");
  AST_CTS_RST: assert property ($rose(RST_B_I) |-> !cts_b)
    else $error("cts set at reset");
  AST_CTS_STOP: assert property ($rose(cts_b) |-> din && $past(din, 2))
    else $error("cts off stop");
  AST_CTS_HYS: assert property ($rose(cts_b) |=> cts_b[*4])
    else $error("cts early");
endmodule : hspf_properties

// ===== sim/testbench.sv
// Bench: host and device ends joined over one link.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/100ps
module testbench;
  logic        clk, rb, ps, pe, pw, pr, we, op, tv, tl, tr, rv, rr, th, sf;
  logic [7:0]  td, rx, ft;
  logic [8:0]  q[$];
  logic [11:0] pa;
  logic [31:0] wd, pd, rd;
  logic [46:0] cf;
  int          fail_count = 0, tests_run = 0, cyc = 0;
  hspf_if link ();
  hspf_dev hspf_dev_inst (.CORE_CLK_I(clk), .RST_B_I(rb), .CE_I(1'h1),
    .LINK(link), .CFG_WE_I(we), .BIT_RATE_SELECT_I(cf[46:23]),
    .PARITY_SELECT_I(cf[22:21]), .STOP_BIT_COUNT_I(cf[20]),
    .PACKET_SILENCE_TIMEOUT_I(cf[19:12]),
    .RX_BUFFER_THROTTLE_LEVEL_I(cf[11:3]), .HOST_FRAMING_MODE_I(cf[2:1]),
    .RX_FRAME_FORMAT_OPTION_I(op), .XOFF_ENABLE_I(cf[0]),
    .RF_TX_VALID_O(tv), .RF_TX_DATA_O(td), .RF_TX_SOF_O(sf),
    .RF_TX_LAST_O(tl), .RF_TX_READY_I(tr), .RF_RX_VALID_I(rv),
    .RF_RX_DATA_I(rx), .RF_RX_SOF_I(1'h0), .RF_RX_READY_O(rr),
    .RX_FRAME_TYPE_O(ft), .THROTTLED_O(th));
  hspf_host hspf_host_inst (.CORE_CLK_I(clk), .RST_B_I(rb), .CE_I(1'h1),
    .PSEL_I(ps), .PENABLE_I(pe), .PWRITE_I(pw), .PADDR_I(pa),
    .PWDATA_I(wd), .PRDATA_O(pd), .PREADY_O(pr), .PSLVERR_O(), .LINK(link));
  hspf_properties hspf_properties_inst (.CORE_CLK_I(clk), .RST_B_I(rb),
    .din(link.din), .dout(link.dout), .cts_b(link.cts_b));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tv && tr) q.push_back({tl || sf, td});
    if (rv && rr) rv <= 1'h0;
    if (cyc == 60000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, s);
    tests_run++;
    if (e !== s) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    @(posedge clk);
    {ps, pw, pa, wd} <= {1'h1, w, a, d};
    @(posedge clk);
    pe <= 1'h1;
    do @(posedge clk); while (pr !== 1'h1);
    rd = pd;
    {ps, pe} <= 2'h0;
  endtask : apb
  task automatic t_packet();
    apb(1'h1, 12'h004, 'hA5);
    apb(1'h1, 12'h004, 'h3C);
    apb(1'h1, 12'h004, 'h81);
    repeat (3000) if (q.size() < 3) @(posedge clk);
    chk("pkt", 32'h0A5_03C, {q[0], 3'h0, q[1]});
    chk("last", 32'h181, q[2]);
  endtask : t_packet
  task automatic t_rx();
    @(posedge clk);
    {rx, rv} <= {8'h7E, 1'h1};
    rd = 32'h0;
    repeat (300) if (rd[10] !== 1'h1) apb(1'h0, 12'h008, 0);
    chk("rx", 32'h47E, rd[10:0]);
  endtask : t_rx
  task automatic t_thr();
    q.delete();
    tr <= 1'h0;
    for (int i = 0; i < 16; i++) apb(1'h1, 12'h004, i);
    repeat (9000) if (th !== 1'h1) @(posedge clk);
    apb(1'h0, 12'h00C, 0);
    chk("stop", 32'h1, rd[6]);
    tr <= 1'h1;
    repeat (9000) if (th !== 1'h0) @(posedge clk);
    chk("resume", 32'h1, q.size() >= 7);
    repeat (9000) if (q.size() < 16) @(posedge clk);
    chk("tail", 32'h10F, q[15]);
  endtask : t_thr
  task automatic t_api();
    cf[2:1] <= 2'h2;
    we <= 1'h1;
    apb(1'h1, 12'h000, 'h316A_CFC0);
    we <= 1'h0;
    q.delete();
    apb(1'h1, 12'h004, 'h17E);
    apb(1'h1, 12'h004, 'h7D);
    apb(1'h1, 12'h004, 'h11);
    repeat (5000) if (q.size() < 3) @(posedge clk);
    chk("sof", 32'h17E, q[0]);
    chk("esc", 32'h07D_011, {q[1], 3'h0, q[2]});
    {rx, rv} <= {8'h13, 1'h1};
    rd = 32'h0;
    repeat (600) if (rd[10] !== 1'h1) apb(1'h0, 12'h008, 0);
    chk("unesc", 32'h413, rd[10:0]);
  endtask : t_api
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    {rb, ps, pe, pw, we, rv, pa, wd, rx} = '0;
    {op, tr, cf} = {2'h3, 24'h6ACFC0, 3'h2, 8'h03, 9'h13F, 3'h0};
    repeat (2) @(posedge clk);
    rb <= 1'h1;
    chk("type", 32'h90, ft);
    we <= 1'h1;
    apb(1'h1, 12'h000, 'h216A_CFC0);
    we <= 1'h0;
    apb(1'h0, 12'h000, 0);
    chk("cfg", 32'h216A_CFC0, rd);
    chk("type", 32'h91, ft);
    t_packet();
    t_rx();
    t_thr();
    t_api();
    give_verdict();
  end
endmodule : testbench
